// File: design/sfd_regs.svh
// Register offsets, field positions, codes and reset values of the file select decoder
`ifndef SFD_REGS_SVH
`define SFD_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SFD_OFF_CTRL 8'h00
`define SFD_OFF_HDR 8'h04
`define SFD_OFF_DATA 8'h08
`define SFD_OFF_STAT 8'h0c
`define SFD_OFF_SWREQ 8'h10
`define SFD_OFF_INFO 8'h14
`define SFD_OFF_CLA 8'h18
`define SFD_OFF_REPORT 8'h1c
// Word index of the first file table, attribute and identifier word
`define SFD_MEM_TBL 5'h08
`define SFD_MEM_ATTR 5'h10
`define SFD_MEM_AID 5'h18
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SFD_CTRL_START 0
`define SFD_CTRL_TOOLKIT 1
`define SFD_CTRL_RECPTR 2
`define SFD_TBL_VALID 23
`define SFD_TBL_KIND 21:20
`define SFD_TBL_PARENT 18:16
`define SFD_TBL_FID 15:0
`define SFD_ATTR_RECLEN 23:16
`define SFD_ATTR_STRUCT 25:24
// ----------------------------------------
// Command codes and status words
// ----------------------------------------
`define SFD_P1_FID 8'h00
`define SFD_P1_CHILD 8'h01
`define SFD_P1_PARENT 8'h03
`define SFD_P1_AID 8'h04
`define SFD_P1_PATH_ROOT 8'h08
`define SFD_P1_PATH_CUR 8'h09
`define SFD_P2_NODATA 8'h0c
`define SFD_P2_RSP_FCP 3'h1
`define SFD_P2_RSP_NONE 3'h3
`define SFD_SW_OK 16'h9000
`define SFD_SW_NOTFOUND 16'h6a82
`define SFD_SW_BADP 16'h6a86
`define SFD_SW_BADLEN 16'h6700
`define SFD_SW_CHAN 16'h6881
`define SFD_SW_TK_HI 8'h91
`define SFD_SW_TK_FULL 16'h9300
`define SFD_ROOT_IDX 3'h0
`define SFD_RST_WORD 32'h0
`endif

// File: design/sfd_pkg.sv
// Types shared by the file select decoder modules
package sfd_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_CHECK = 5'h02,
		ST_PH1 = 5'h04,
		ST_PH2 = 5'h08,
		ST_PH3 = 5'h10
	} sfd_state_t;
	typedef enum logic [1:0] {K_ROOT = 2'h0, K_DIR = 2'h1, K_APP = 2'h2, K_EF = 2'h3} sfd_kind_t;
	typedef enum logic [1:0] {SC_CHILD = 2'h0, SC_DIR = 2'h1, SC_AID = 2'h2} sfd_scan_t;
	typedef struct packed {
		logic valid;
		sfd_kind_t kind;
		logic [2:0] parent;
		logic [15:0] file_identifier;
	} sfd_entry_t;
	typedef struct packed {
		sfd_scan_t mode;
		logic [2:0] parent;
		logic [15:0] file_identifier;
		logic [31:0] application_identifier;
		logic [31:0] mask;
		logic [2:0] ref_idx;
	} sfd_key_t;
	typedef struct packed {
		logic hit;
		logic [2:0] first;
		logic [2:0] last;
		logic nhit;
		logic [2:0] next;
		logic phit;
		logic [2:0] prev;
	} sfd_res_t;
endpackage : sfd_pkg

// File: design/sfd_scan.sv
// Combinational scan of the file table for one search key
`timescale 1ns/1ps
`default_nettype none
module sfd_scan (
	input wire sfd_pkg::sfd_entry_t [7:0] i_tbl,
	input wire logic [7:0][31:0] i_aid,
	input wire sfd_pkg::sfd_key_t i_key,
	output var sfd_pkg::sfd_res_t o_res
);
	import sfd_pkg::*;

	logic [7:0] match;
	logic [7:0] up;
	logic [7:0] dn;

	function automatic logic [2:0] lowest(input logic [7:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : lowest

	function automatic logic [2:0] highest(input logic [7:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : highest

	// ----------------------------------------
	// Per-entry match
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_ent
			logic is_dir;
			logic fid_ok;
			logic aid_ok;
			assign is_dir = (i_tbl[g].kind == K_DIR) || (i_tbl[g].kind == K_APP);
			// A directory never counts as its own child, so the root is skipped
			assign fid_ok = i_tbl[g].valid && (i_tbl[g].parent == i_key.parent)
				&& (3'(g) != i_key.parent) && (i_tbl[g].file_identifier == i_key.file_identifier);
			// Truncated identifiers compare only the bytes the mask keeps
			assign aid_ok = i_tbl[g].valid && (i_tbl[g].kind == K_APP)
				&& (((i_aid[g] ^ i_key.application_identifier) & i_key.mask) == 32'h0);
			assign match[g] = (i_key.mode == SC_AID) ? aid_ok
				: (fid_ok && ((i_key.mode == SC_CHILD) || is_dir));
		end
	endgenerate

	// ----------------------------------------
	// Occurrence pick
	// ----------------------------------------
	assign up = match & (8'hfe << i_key.ref_idx);
	assign dn = match & ~(8'hff << i_key.ref_idx);
	assign o_res = '{hit: |match, first: lowest(match), last: highest(match),
		nhit: |up, next: lowest(up), phit: |dn, prev: highest(dn)};
endmodule : sfd_scan
`default_nettype wire

// File: design/sfd_top.sv
// File select command decoder with its Avalon-MM register slave
// Behaviour
// - Successful selection leaves record pointer undefined
// - First parameter byte chooses selection method
// - P2 b7..b6 session control, identifier selection only
// - P2 b2..b1 pick first/last/next/previous occurrence
// - Empty data with P1 00 and P2 0C selects root
// - Identifier search: children, parent, parent's children
// - Truncated application identifier matched against stored
// - Only the basic logical channel is used
// - Toolkit status words only for toolkit terminals
// - Elementary file report: sizes, access, structure, records
// - Directory report: id, size, code status, data
`timescale 1ns/1ps
`default_nettype none
`include "sfd_regs.svh"
module sfd_top (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest
);
	import sfd_pkg::*;

	logic req, ack_r, wr_en, in_mem, busy, start;
	logic [31:0] rdata_r, rdata_nxt, report;
	logic [31:0] hdr_r, data_r;
	logic [7:0] cla_r, p1, p2, lc;
	logic toolkit_r, rec_ptr_r, done_r, fcp_r;
	logic [31:0] mem_r [8:31];
	logic [7:0][31:0] aid_w;
	sfd_entry_t [7:0] ent;
	sfd_state_t state_r, state_nxt;
	sfd_key_t key_r, key_nxt;
	sfd_res_t scan;
	logic [2:0] cur_dir_r, cur_file_r, cur_app_r, sel_r, sel_idx;
	logic [1:0] session_r;
	logic [15:0] sw_r, err_sw;
	logic sel_go, err_go;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	function automatic logic p1_known(input logic [7:0] v);
		return (v == `SFD_P1_FID) || (v == `SFD_P1_CHILD) || (v == `SFD_P1_PARENT)
			|| (v == `SFD_P1_AID) || (v == `SFD_P1_PATH_ROOT) || (v == `SFD_P1_PATH_CUR);
	endfunction : p1_known

	function automatic logic [31:0] aid_mask(input logic [7:0] n);
		logic [31:0] m;
		unique case (n)
			8'h01: m = 32'hff000000;
			8'h02: m = 32'hffff0000;
			8'h03: m = 32'hffffff00;
			default: m = 32'hffffffff;
		endcase
		return m;
	endfunction : aid_mask

	// ----------------------------------------
	// Avalon-MM slave: one wait state per access
	// ----------------------------------------
	assign req = i_avs_read || i_avs_write;
	assign o_avs_waitrequest = req && !ack_r;
	assign wr_en = i_avs_write && ack_r;
	assign o_avs_readdata = rdata_r;
	assign in_mem = !i_avs_address[7] && (i_avs_address[6:5] != 2'h0);
	assign busy = (state_r != ST_IDLE);
	assign start = wr_en && (i_avs_address == `SFD_OFF_CTRL) && i_avs_byteenable[0]
		&& i_avs_writedata[`SFD_CTRL_START] && !busy;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ack_r <= 1'b0;
			rdata_r <= `SFD_RST_WORD;
		end else begin
			ack_r <= req && !ack_r;
			if (i_avs_read && !ack_r) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	// ----------------------------------------
	// Command registers; frozen while a selection runs
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			hdr_r <= `SFD_RST_WORD;
			data_r <= `SFD_RST_WORD;
			cla_r <= 8'h00;
			toolkit_r <= 1'b0;
		end else if (wr_en && !busy) begin
			if (i_avs_address == `SFD_OFF_HDR) begin
				hdr_r <= be_merge(hdr_r, i_avs_writedata, i_avs_byteenable);
			end
			if (i_avs_address == `SFD_OFF_DATA) begin
				data_r <= be_merge(data_r, i_avs_writedata, i_avs_byteenable);
			end
			if (i_avs_address == `SFD_OFF_CLA && i_avs_byteenable[0]) begin
				cla_r <= i_avs_writedata[7:0];
			end
			if (i_avs_address == `SFD_OFF_CTRL && i_avs_byteenable[0]) begin
				toolkit_r <= i_avs_writedata[`SFD_CTRL_TOOLKIT];
			end
		end
	end
	assign p1 = hdr_r[7:0];
	assign p2 = hdr_r[15:8];
	assign lc = hdr_r[23:16];

	// ----------------------------------------
	// File table, attribute and identifier words
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 8; i < 32; i++) begin
				mem_r[i] <= `SFD_RST_WORD;
			end
		end else if (wr_en && in_mem && !busy) begin
			mem_r[i_avs_address[6:2]] <= be_merge(mem_r[i_avs_address[6:2]],
				i_avs_writedata, i_avs_byteenable);
		end
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_tbl
			assign ent[g] = '{valid: mem_r[8+g][`SFD_TBL_VALID],
				kind: sfd_kind_t'(mem_r[8+g][`SFD_TBL_KIND]),
				parent: mem_r[8+g][`SFD_TBL_PARENT], file_identifier: mem_r[8+g][`SFD_TBL_FID]};
			assign aid_w[g] = mem_r[24+g];
		end
	endgenerate

	sfd_scan u_scan (
		.i_tbl(ent),
		.i_aid(aid_w),
		.i_key(key_r),
		.o_res(scan)
	);

	// ----------------------------------------
	// Selection sequencer
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		key_nxt = key_r;
		sel_go = 1'b0;
		sel_idx = 3'h0;
		err_go = 1'b0;
		err_sw = `SFD_SW_OK;
		unique case (state_r)
			ST_IDLE: begin
				if (start) begin
					state_nxt = ST_CHECK;
				end
			end
			ST_CHECK: begin
				state_nxt = ST_IDLE;
				key_nxt = '{mode: SC_CHILD, parent: cur_dir_r, file_identifier: data_r[31:16],
					application_identifier: data_r, mask: aid_mask(lc), ref_idx: cur_app_r};
				if (cla_r[1:0] != 2'h0) begin
					err_go = 1'b1;
					err_sw = `SFD_SW_CHAN;
				end else if (p2[7] || ((p2[4:2] != `SFD_P2_RSP_FCP)
					&& (p2[4:2] != `SFD_P2_RSP_NONE))) begin
					err_go = 1'b1;
					err_sw = `SFD_SW_BADP;
				end else begin
					unique case (p1)
						`SFD_P1_FID: begin
							if (lc == 8'h00) begin
								// Empty data must come with no-data response
								if (p2 == `SFD_P2_NODATA) begin
									sel_go = 1'b1;
									sel_idx = `SFD_ROOT_IDX;
								end else begin
									err_go = 1'b1;
									err_sw = `SFD_SW_BADP;
								end
							end else if (lc != 8'h02) begin
								err_go = 1'b1;
								err_sw = `SFD_SW_BADLEN;
							end else begin
								state_nxt = ST_PH1;
							end
						end
						`SFD_P1_CHILD: begin
							key_nxt.mode = SC_DIR;
							if (lc != 8'h02) begin
								err_go = 1'b1;
								err_sw = `SFD_SW_BADLEN;
							end else begin
								state_nxt = ST_PH1;
							end
						end
						`SFD_P1_PARENT: begin
							sel_go = 1'b1;
							sel_idx = ent[cur_dir_r].parent;
						end
						`SFD_P1_AID: begin
							key_nxt.mode = SC_AID;
							if (lc == 8'h00) begin
								err_go = 1'b1;
								err_sw = `SFD_SW_BADLEN;
							end else begin
								state_nxt = ST_PH1;
							end
						end
						`SFD_P1_PATH_ROOT, `SFD_P1_PATH_CUR: begin
							if (p1 == `SFD_P1_PATH_ROOT) begin
								key_nxt.parent = `SFD_ROOT_IDX;
							end
							if (lc != 8'h02 && lc != 8'h04) begin
								err_go = 1'b1;
								err_sw = `SFD_SW_BADLEN;
							end else begin
								state_nxt = ST_PH1;
							end
						end
						default: begin
							err_go = 1'b1;
							err_sw = `SFD_SW_BADP;
						end
					endcase
				end
			end
			ST_PH1: begin
				state_nxt = ST_IDLE;
				if (p1 == `SFD_P1_AID) begin
					// Occurrence bits are read only here
					unique case (p2[1:0])
						2'h0: begin sel_go = scan.hit; sel_idx = scan.first; end
						2'h1: begin sel_go = scan.hit; sel_idx = scan.last; end
						2'h2: begin sel_go = scan.nhit; sel_idx = scan.next; end
						2'h3: begin sel_go = scan.phit; sel_idx = scan.prev; end
					endcase
					err_go = !sel_go;
					err_sw = `SFD_SW_NOTFOUND;
				end else if (scan.hit && lc == 8'h04 && p1 != `SFD_P1_FID) begin
					// Second path element is a child of the first
					if (ent[scan.first].kind != K_EF) begin
						key_nxt.parent = scan.first;
						key_nxt.file_identifier = data_r[15:0];
						state_nxt = ST_PH3;
					end else begin
						err_go = 1'b1;
						err_sw = `SFD_SW_NOTFOUND;
					end
				end else if (scan.hit) begin
					sel_go = 1'b1;
					sel_idx = scan.first;
				end else if (p1 == `SFD_P1_FID) begin
					key_nxt.parent = ent[cur_dir_r].parent;
					state_nxt = ST_PH2;
				end else begin
					err_go = 1'b1;
					err_sw = `SFD_SW_NOTFOUND;
				end
			end
			ST_PH2: begin
				if (ent[key_r.parent].file_identifier == key_r.file_identifier) begin
					sel_go = 1'b1;
					sel_idx = key_r.parent;
					state_nxt = ST_IDLE;
				end else begin
					state_nxt = ST_PH3;
				end
			end
			ST_PH3: begin
				state_nxt = ST_IDLE;
				sel_go = scan.hit;
				sel_idx = scan.first;
				err_go = !scan.hit;
				err_sw = `SFD_SW_NOTFOUND;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= ST_IDLE;
			key_r <= '0;
		end else begin
			state_r <= state_nxt;
			key_r <= key_nxt;
		end
	end

	// ----------------------------------------
	// Current selection; untouched on any error
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cur_dir_r <= `SFD_ROOT_IDX;
			cur_file_r <= `SFD_ROOT_IDX;
			cur_app_r <= `SFD_ROOT_IDX;
			sel_r <= `SFD_ROOT_IDX;
			fcp_r <= 1'b0;
			session_r <= 2'h0;
		end else if (sel_go) begin
			sel_r <= sel_idx;
			fcp_r <= (p2[4:2] == `SFD_P2_RSP_FCP);
			if (ent[sel_idx].kind == K_EF) begin
				cur_file_r <= sel_idx;
				cur_dir_r <= ent[sel_idx].parent;
			end else begin
				cur_file_r <= sel_idx;
				cur_dir_r <= sel_idx;
			end
			if (ent[sel_idx].kind == K_APP) begin
				cur_app_r <= sel_idx;
			end
			if (p1 == `SFD_P1_AID) begin
				session_r <= p2[6:5];
			end
		end
	end

	// ----------------------------------------
	// Status word, completion and record pointer
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sw_r <= `SFD_SW_OK;
			done_r <= 1'b0;
			rec_ptr_r <= 1'b0;
		end else begin
			if (err_go) begin
				sw_r <= err_sw;
			end else if (sel_go) begin
				sw_r <= `SFD_SW_OK;
			end else if (wr_en && i_avs_address == `SFD_OFF_SWREQ && !busy) begin
				// Toolkit-only words fall back to plain success
				if (!toolkit_r && ((i_avs_writedata[15:8] == `SFD_SW_TK_HI)
					|| (i_avs_writedata[15:0] == `SFD_SW_TK_FULL))) begin
					sw_r <= `SFD_SW_OK;
				end else begin
					sw_r <= i_avs_writedata[15:0];
				end
			end
			if (start) begin
				done_r <= 1'b0;
			end else if (sel_go || err_go) begin
				done_r <= 1'b1;
			end
			// A completed selection wins over a software set in the same cycle
			if (sel_go) begin
				rec_ptr_r <= 1'b0;
			end else if (wr_en && i_avs_address == `SFD_OFF_CTRL && i_avs_byteenable[0]
				&& i_avs_writedata[`SFD_CTRL_RECPTR]) begin
				rec_ptr_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Report of the selected file and read mux
	// ----------------------------------------
	always_comb begin
		report = fcp_r ? mem_r[16 + 32'(sel_r)] : `SFD_RST_WORD;
		if (ent[sel_r].kind == K_EF && report[`SFD_ATTR_STRUCT] == 2'h0) begin
			report[`SFD_ATTR_RECLEN] = 8'h00;
		end
	end

	always_comb begin
		rdata_nxt = `SFD_RST_WORD;
		if (in_mem) begin
			rdata_nxt = mem_r[i_avs_address[6:2]];
		end else begin
			unique case (i_avs_address)
				`SFD_OFF_CTRL: rdata_nxt = {29'h0, rec_ptr_r, toolkit_r, 1'b0};
				`SFD_OFF_HDR: rdata_nxt = hdr_r;
				`SFD_OFF_DATA: rdata_nxt = data_r;
				`SFD_OFF_STAT: rdata_nxt = {cur_app_r, 1'b0, session_r, fcp_r, rec_ptr_r,
					cur_file_r, cur_dir_r, done_r, busy, sw_r};
				`SFD_OFF_INFO: rdata_nxt = {13'h0, fcp_r, ent[sel_r].kind, ent[sel_r].file_identifier};
				`SFD_OFF_CLA: rdata_nxt = {24'h0, cla_r};
				`SFD_OFF_REPORT: rdata_nxt = report;
				default: rdata_nxt = `SFD_RST_WORD;
			endcase
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	property p_rec_ptr;
		sel_go |=> !rec_ptr_r;
	endproperty
	a_rec_ptr: assert property (p_rec_ptr) else $error("record pointer kept");
	property p_bad_p1;
		(state_r == ST_CHECK) && (cla_r[1:0] == 2'h0) && !p2[7]
			&& (p2[4:2] == `SFD_P2_RSP_NONE) && !p1_known(p1)
			|=> (sw_r == `SFD_SW_BADP) && $stable(cur_dir_r) && $stable(cur_file_r) && done_r;
	endproperty
	a_bad_p1: assert property (p_bad_p1) else $error("unknown P1 not rejected");
	property p_p2;
		(state_r == ST_CHECK) && (cla_r[1:0] == 2'h0) && p2[7] |=> sw_r == `SFD_SW_BADP;
	endproperty
	a_p2: assert property (p_p2) else $error("P2 b8 set not rejected");
	property p_root;
		(state_r == ST_CHECK) && (cla_r[1:0] == 2'h0) && (p1 == `SFD_P1_FID) && (lc == 8'h00)
			&& (p2 == `SFD_P2_NODATA) |=> (cur_dir_r == `SFD_ROOT_IDX) && (sw_r == `SFD_SW_OK);
	endproperty
	a_root: assert property (p_root) else $error("root not selected");
	property p_order;
		(state_r == ST_PH2) |-> ($past(state_r) == ST_PH1) && !$past(scan.hit);
	endproperty
	a_order: assert property (p_order) else $error("parent checked too early");
	property p_phase3;
		(state_r == ST_PH3) && (p1 == `SFD_P1_FID) |-> $past(state_r) == ST_PH2;
	endproperty
	a_phase3: assert property (p_phase3) else $error("search order broken");
	property p_chan;
		(state_r == ST_CHECK) && (cla_r[1:0] != 2'h0) |=> (sw_r == `SFD_SW_CHAN) && done_r;
	endproperty
	a_chan: assert property (p_chan) else $error("extra channel accepted");
	property p_toolkit;
		wr_en && (i_avs_address == `SFD_OFF_SWREQ) && !busy && !toolkit_r
			|=> (sw_r[15:8] != `SFD_SW_TK_HI) && (sw_r != `SFD_SW_TK_FULL);
	endproperty
	a_toolkit: assert property (p_toolkit) else $error("toolkit word leaked");
	property p_session;
		sel_go && (p1 != `SFD_P1_AID) |=> $stable(session_r);
	endproperty
	a_session: assert property (p_session) else $error("session changed");
	property p_done;
		start |-> ##[2:5] done_r;
	endproperty
	a_done: assert property (p_done) else $error("selection did not finish");
	property p_wait;
		req && o_avs_waitrequest |=> !o_avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("waitrequest held too long");

	c_root: cover property ((state_r == ST_CHECK) && (p1 == `SFD_P1_FID) && (lc == 8'h00) && sel_go);
	c_ph3: cover property ((state_r == ST_PH3) && scan.hit);
	c_aid: cover property ((state_r == ST_PH1) && (p1 == `SFD_P1_AID) && sel_go);
	c_err: cover property (err_go && (err_sw == `SFD_SW_NOTFOUND));
endmodule : sfd_top
`default_nettype wire

// File: bench/sfd_term_model.sv
// Terminal-side bus master issuing register accesses to the decoder
`timescale 1ns/1ps
`default_nettype none
module sfd_term_model (
	input wire logic i_clk,
	input wire logic [31:0] i_readdata,
	input wire logic i_waitrequest,
	output logic [7:0] o_address,
	output logic o_read,
	output logic o_write,
	output logic [31:0] o_writedata,
	output logic [3:0] o_byteenable,
	output logic o_hang
);
	initial begin
		o_address = 8'h00;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h0;
		o_byteenable = 4'hf;
		o_hang = 1'b0;
	end
	// ----------------------------------------
	// Bus cycle
	// ----------------------------------------
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_clk);
		o_address <= a;
		o_writedata <= d;
		o_write <= w;
		o_read <= !w;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_waitrequest !== 1'b0 && n < 50);
		q = i_readdata;
		if (n >= 50) o_hang <= 1'b1;
		o_write <= 1'b0;
		o_read <= 1'b0;
		// Released lines show the inverse so a stale value is never trusted
		o_address <= ~a;
		o_writedata <= ~d;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(a, 1'b0, 32'h0, q);
	endtask : rd
endmodule : sfd_term_model
`default_nettype wire

// File: bench/file_select_command_decoder_tb_top.sv
// Self-checking bench for the file select command decoder
`timescale 1ns/1ps
`default_nettype none
`include "sfd_regs.svh"
module file_select_command_decoder_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr;
	logic bus_rd, bus_wr, hang, bus_wait;
	logic [31:0] wdat, rdat, st, rv;
	logic [3:0] be;
	int err_total = 0;
	int total_checks = 0;
	always #25 clk = ~clk;
	sfd_top dut (.i_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(bus_rd),
		.i_avs_write(bus_wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
		.o_avs_readdata(rdat), .o_avs_waitrequest(bus_wait));
	sfd_term_model term (.i_clk(clk), .i_readdata(rdat), .i_waitrequest(bus_wait),
		.o_address(adr), .o_read(bus_rd), .o_write(bus_wr), .o_writedata(wdat),
		.o_byteenable(be), .o_hang(hang));
	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task final_report;
		if (err_total == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report
	always @(posedge clk) begin
		if (hang === 1'b1) begin
			err_total++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Header first, then data, then start; poll until done
	task automatic go(input logic [7:0] p1, input logic [7:0] p2, input logic [7:0] lc,
		input logic [31:0] d);
		int n;
		term.wr(`SFD_OFF_HDR, {8'h00, lc, p2, p1});
		term.wr(`SFD_OFF_DATA, d);
		term.wr(`SFD_OFF_CTRL, 32'h1);
		n = 0;
		do begin
			term.rd(`SFD_OFF_STAT, st);
			n++;
		end while (st[17] !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			final_report();
		end
	endtask : go
	task automatic cs(input logic [15:0] sw, input logic [2:0] dir);
		chk(32'(st[15:0]), 32'(sw));
		chk(32'(st[20:18]), 32'(dir));
	endtask : cs
	task automatic cf(input logic [2:0] f);
		chk(32'(st[23:21]), 32'(f));
	endtask : cf
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		term.rd(`SFD_OFF_STAT, rv);
		chk(rv, 32'h00009000);
		term.wr(8'h84, 32'h12345678);
		term.rd(8'h84, rv);
		chk(rv, 32'h0);
		term.wr(8'h20, 32'h00803f00);
		term.wr(8'h24, 32'h00907f10);
		term.wr(8'h28, 32'h00b16f07);
		term.wr(8'h2c, 32'h00a07fff);
		term.wr(8'h30, 32'h00907f20);
		term.wr(8'h34, 32'h00b06f07);
		term.wr(8'h48, 32'h01100020);
		term.wr(8'h6c, 32'ha0000087);
		term.wr(8'h38, 32'h00a07ffe);
		term.wr(8'h78, 32'ha0000099);
		term.wr(8'h44, 32'h00a51234);
		term.wr(8'h54, 32'h00220040);
		term.wr(`SFD_OFF_CTRL, 32'h4);
		term.rd(`SFD_OFF_STAT, rv);
		chk(32'(rv[24]), 32'h1);
		go(8'h00, 8'h0f, 8'h02, 32'h7f100000);
		cs(16'h9000, 3'h1);
		chk(32'(st[24]), 32'h0);
		go(8'h00, 8'h04, 8'h02, 32'h6f070000);
		cs(16'h9000, 3'h1);
		cf(3'h2);
		chk(32'(st[25]), 32'h1);
		term.rd(`SFD_OFF_REPORT, rv);
		chk(rv, 32'h01100020);
		term.rd(`SFD_OFF_INFO, rv);
		chk(rv, 32'h00076f07);
		go(8'h00, 8'h8c, 8'h02, 32'h6f070000);
		cs(16'h6a86, 3'h1);
		go(8'h02, 8'h0c, 8'h02, 32'h6f070000);
		cs(16'h6a86, 3'h1);
		cf(3'h2);
		term.wr(`SFD_OFF_CLA, 32'h1);
		go(8'h00, 8'h0c, 8'h02, 32'h6f070000);
		cs(16'h6881, 3'h1);
		cf(3'h2);
		term.wr(`SFD_OFF_CLA, 32'h0);
		go(8'h03, 8'h0c, 8'h00, 32'h0);
		cs(16'h9000, 3'h0);
		go(8'h01, 8'h04, 8'h02, 32'h7f100000);
		cs(16'h9000, 3'h1);
		term.rd(`SFD_OFF_REPORT, rv);
		chk(rv, 32'h00a51234);
		go(8'h00, 8'h0c, 8'h02, 32'h3f000000);
		cs(16'h9000, 3'h0);
		go(8'h01, 8'h0c, 8'h02, 32'h7f100000);
		go(8'h00, 8'h0c, 8'h02, 32'h7f200000);
		cs(16'h9000, 3'h4);
		go(8'h00, 8'h04, 8'h02, 32'h6f070000);
		cs(16'h9000, 3'h0);
		cf(3'h5);
		term.rd(`SFD_OFF_REPORT, rv);
		chk(rv, 32'h00000040);
		go(8'h08, 8'h0c, 8'h04, 32'h7f106f07);
		cs(16'h9000, 3'h1);
		cf(3'h2);
		go(8'h00, 8'h04, 8'h00, 32'h0);
		cs(16'h6a86, 3'h1);
		go(8'h00, 8'h0c, 8'h00, 32'h0);
		cs(16'h9000, 3'h0);
		go(8'h09, 8'h0c, 8'h04, 32'h7f106f07);
		cs(16'h9000, 3'h1);
		cf(3'h2);
		go(8'h04, 8'h4c, 8'h02, 32'ha0000000);
		cs(16'h9000, 3'h3);
		chk(32'(st[31:29]), 32'h3);
		chk(32'(st[27:26]), 32'h2);
		for (int q = 0; q < 2; q++) begin
			go(8'h04, {6'h03, 2'(q)}, 8'h04, 32'ha0000087);
			chk(32'(st[31:29]), 32'h3);
			chk(32'(st[27:26]), 32'h0);
		end
		go(8'h04, 8'h0e, 8'h02, 32'ha0000000);
		chk(32'(st[31:29]), 32'h6);
		go(8'h04, 8'h0f, 8'h02, 32'ha0000000);
		chk(32'(st[31:29]), 32'h3);
		go(8'h04, 8'h0e, 8'h04, 32'ha0000087);
		cs(16'h6a82, 3'h3);
		for (int t = 0; t < 2; t++) begin
			term.wr(`SFD_OFF_CTRL, 32'(t) << 1);
			term.wr(`SFD_OFF_SWREQ, 32'h9300);
			term.rd(`SFD_OFF_STAT, rv);
			chk(32'(rv[15:0]), t ? 32'h9300 : 32'h9000);
			term.wr(`SFD_OFF_SWREQ, 32'h9123);
			term.rd(`SFD_OFF_STAT, rv);
			chk(32'(rv[15:0]), t ? 32'h9123 : 32'h9000);
		end
		final_report();
	end
endmodule : file_select_command_decoder_tb_top
`default_nettype wire
